// ### verilog/lpi_pkg.sv
// Behaviour
// (RULE_01) tx ALERT sends repeating 16-bit 0xff00; code sends it only with shutdown_en set, else the idle word LPI_DAT
// (RULE_02) tx QUIET disables the transmit lanes
// (RULE_03) received ALERT sends 0xff00 onward
// (RULE_04) received QUIET disables receive-direction lanes
// (RULE_05) rx DATA to QUIET drops signal detect
// (RULE_06) ALERT during QUIET raises detect within 500ns
// (RULE_07) in QUIET only ALERT raises detect
// (RULE_08) fault indication overrides low power idle
// (RULE_09) wake hold differs with scrambler bypass
// (RULE_10) no refresh-alert state exists
// (RULE_11) tx_mode takes one of five values
// (RULE_12) lane priority: fault, idle request, data
// (RULE_13) pattern restarts on entry, stops on exit
package lpi_pkg;
	// ****************************************
	// lane carrier and modes
	// ****************************************
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int BUS_W = LANES * LANE_W;

	typedef struct packed {
		logic [LANES-1:0] ctl;
		logic [BUS_W-1:0] dat;
	} lpi_lane_t;

	typedef enum logic [2:0] {
		LPI_M_DATA = 3'h0,
		LPI_M_SLEEP = 3'h1,
		LPI_M_QUIET = 3'h2,
		LPI_M_FW = 3'h3,
		LPI_M_ALERT = 3'h4
	} lpi_mode_t;

	// gray codes along active, sleep, quiet, wake
	typedef enum logic [2:0] {
		LPI_S_ACTIVE = 3'h0,
		LPI_S_SLEEP = 3'h1,
		LPI_S_QUIET = 3'h3,
		LPI_S_WAKE = 3'h2,
		LPI_S_FAST = 3'h6
	} lpi_state_t;

	// ****************************************
	// patterns and control words
	// ****************************************
	localparam logic [15:0] ALERT_PAT = 16'hff00;
	localparam logic [LANES-1:0] CTL_ALL = 4'hf;
	localparam logic [LANES-1:0] CTL_NONE = 4'h0;
	localparam logic [BUS_W-1:0] FAULT_DAT = 32'h0200009c;
	localparam logic [LANES-1:0] FAULT_CTL = 4'h1;
	localparam logic [BUS_W-1:0] LPI_DAT = 32'h06060606;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_NS = 10;
	localparam int WAKE_NS_SCR = 3900;
	localparam int WAKE_NS_BYP = 2400;
	localparam int SLEEP_NS = 200;
	localparam int SD_MAX_NS = 500;
	localparam logic [9:0] WAKE_CYC_SCR = 10'((WAKE_NS_SCR + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] WAKE_CYC_BYP = 10'((WAKE_NS_BYP + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] SLEEP_CYC = 10'((SLEEP_NS + CLK_NS - 1) / CLK_NS);
	localparam int SD_MAX_CYC = SD_MAX_NS / CLK_NS;
endpackage : lpi_pkg

// ### verilog/lpi_ctrl.sv
`timescale 1ns/100ps
module lpi_ctrl import lpi_pkg::*; #(
	parameter int FW_WAKE_NS = 1000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic shutdown_en,
	input wire logic fast_wake_select,
	input wire logic scrambler_bypass_on,
	input wire logic lpi_request,
	input wire logic fault_request,
	input wire lpi_lane_t tx_data_in,
	input wire lpi_mode_t rx_mode_in,
	input wire lpi_lane_t rx_data_in,
	input wire logic rx_alert_pin,
	input wire logic rx_energy_pin,
	output lpi_mode_t tx_mode,
	output lpi_lane_t tx_lane_out,
	output logic tx_lane_en,
	output lpi_lane_t rx_lane_out,
	output logic rx_lane_en,
	output logic signal_ok
);
	localparam logic [9:0] WAKE_CYC_FW = 10'((FW_WAKE_NS + CLK_NS - 1) / CLK_NS);
	// local copy so the detect bound is a plain int of this file
	localparam int SD_LIMIT = SD_MAX_CYC;

	typedef struct packed {
		lpi_state_t st;
		logic [9:0] cnt;
		lpi_mode_t mode;
		logic tx_ph;
		logic rx_ph;
		lpi_lane_t tx_out;
		logic tx_en;
		lpi_lane_t rx_out;
		logic rx_en;
		lpi_mode_t rxm_prev;
		logic sig_ok;
		logic alert_s1;
		logic alert_s2;
		logic energy_s1;
		logic energy_s2;
	} lpi_regs_t;

	lpi_regs_t r;
	lpi_regs_t next_r;
	logic [9:0] wake_len;

	// ****************************************
	// wake hold selection
	// ****************************************
	// (RULE_09) hold per bypass
	always_comb begin
		if (fast_wake_select) begin
			wake_len = WAKE_CYC_FW;
		end else if (scrambler_bypass_on) begin
			wake_len = WAKE_CYC_BYP;
		end else begin
			wake_len = WAKE_CYC_SCR;
		end
	end

	// ****************************************
	// next-state logic
	// ****************************************
	// whole block state in one pass; pins go through two flops first
	always_comb begin
		next_r = r;
		next_r.alert_s1 = rx_alert_pin;
		next_r.alert_s2 = r.alert_s1;
		next_r.energy_s1 = rx_energy_pin;
		next_r.energy_s2 = r.energy_s1;
		next_r.rxm_prev = rx_mode_in;
		if (r.cnt != 10'h0) begin
			next_r.cnt = r.cnt - 10'h1;
		end
		// (RULE_10) no refresh-alert state
		case (r.st)
			LPI_S_ACTIVE: begin
				if (lpi_request && !fault_request) begin
					next_r.st = fast_wake_select ? LPI_S_FAST : LPI_S_SLEEP;
					next_r.cnt = SLEEP_CYC;
				end
			end
			LPI_S_SLEEP: begin
				if (!lpi_request) begin
					next_r.st = LPI_S_WAKE;
					next_r.cnt = wake_len;
				end else if (r.cnt == 10'h0) begin
					next_r.st = LPI_S_QUIET;
				end
			end
			LPI_S_QUIET: begin
				if (!lpi_request) begin
					next_r.st = LPI_S_WAKE;
					next_r.cnt = wake_len;
				end
			end
			LPI_S_FAST: begin
				if (!lpi_request) begin
					next_r.st = LPI_S_WAKE;
					next_r.cnt = wake_len;
				end
			end
			LPI_S_WAKE: begin
				if (r.cnt == 10'h0) begin
					next_r.st = LPI_S_ACTIVE;
				end
			end
			default: begin
				next_r.st = LPI_S_ACTIVE;
			end
		endcase
		// (RULE_08) fault wins over idle
		if (fault_request) begin
			next_r.st = LPI_S_ACTIVE;
			next_r.cnt = 10'h0;
		end
		// (RULE_11) one of five modes
		case (next_r.st)
			LPI_S_SLEEP: next_r.mode = LPI_M_SLEEP;
			LPI_S_QUIET: next_r.mode = LPI_M_QUIET;
			LPI_S_FAST: next_r.mode = LPI_M_FW;
			LPI_S_WAKE: next_r.mode = fast_wake_select ? LPI_M_FW : LPI_M_ALERT;
			default: next_r.mode = LPI_M_DATA;
		endcase

		// transmit lanes
		// (RULE_13) phase restarts on entry
		next_r.tx_ph = (next_r.mode == LPI_M_ALERT) && (r.mode == LPI_M_ALERT) ? !r.tx_ph : 1'b0;
		// (RULE_02) quiet turns lanes off
		next_r.tx_en = (next_r.mode != LPI_M_QUIET);
		// (RULE_12) fault, idle, then data
		if (fault_request) begin
			next_r.tx_out.ctl = FAULT_CTL;
			next_r.tx_out.dat = FAULT_DAT;
		end else if (next_r.mode == LPI_M_ALERT && shutdown_en) begin
			// (RULE_01) alert pattern out
			next_r.tx_out.ctl = CTL_NONE;
			next_r.tx_out.dat = {LANES{next_r.tx_ph ? ALERT_PAT[7:0] : ALERT_PAT[15:8]}};
		end else if (lpi_request || next_r.mode != LPI_M_DATA) begin
			next_r.tx_out.ctl = CTL_ALL;
			next_r.tx_out.dat = LPI_DAT;
		end else begin
			next_r.tx_out = tx_data_in;
		end

		// receive-direction lanes
		next_r.rx_ph = (rx_mode_in == LPI_M_ALERT) && (r.rxm_prev == LPI_M_ALERT) ? !r.rx_ph : 1'b0;
		// (RULE_04) received quiet turns lanes off
		next_r.rx_en = (rx_mode_in != LPI_M_QUIET);
		if (rx_mode_in == LPI_M_ALERT) begin
			// (RULE_03) alert pattern onward
			next_r.rx_out.ctl = CTL_NONE;
			next_r.rx_out.dat = {LANES{next_r.rx_ph ? ALERT_PAT[7:0] : ALERT_PAT[15:8]}};
		end else begin
			next_r.rx_out = rx_data_in;
		end

		// signal detect
		if (r.rxm_prev == LPI_M_DATA && rx_mode_in == LPI_M_QUIET) begin
			// (RULE_05) drop on quiet entry
			next_r.sig_ok = 1'b0;
		end else if (rx_mode_in == LPI_M_QUIET) begin
			// (RULE_07) only alert raises it
			// (RULE_06) synced alert sets
			if (r.alert_s2) begin
				next_r.sig_ok = 1'b1;
			end
		end else begin
			next_r.sig_ok = r.energy_s2;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= '{st: LPI_S_ACTIVE, mode: LPI_M_DATA, rxm_prev: LPI_M_DATA, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign tx_mode = r.mode;
	assign tx_lane_out = r.tx_out;
	assign tx_lane_en = r.tx_en;
	assign rx_lane_out = r.rx_out;
	assign rx_lane_en = r.rx_en;
	assign signal_ok = r.sig_ok;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence alert_two_words;
		tx_mode == LPI_M_ALERT && tx_lane_out.dat == {LANES{ALERT_PAT[15:8]}} ##1
		tx_mode == LPI_M_ALERT && tx_lane_out.dat == {LANES{ALERT_PAT[7:0]}};
	endsequence

	sequence alert_entry;
		tx_mode != LPI_M_ALERT ##1 tx_mode == LPI_M_ALERT;
	endsequence

	tx_alert_pat_a: assert property ( // RULE_01
		(alert_entry ##0 $past(shutdown_en)) |->
		tx_lane_out.ctl == CTL_NONE && tx_lane_out.dat == {LANES{ALERT_PAT[15:8]}}
	) else $error("alert pattern wrong");

	tx_quiet_off_a: assert property ( // RULE_02
		tx_mode == LPI_M_QUIET |-> !tx_lane_en
	) else $error("lanes on in quiet");

	rx_alert_pat_a: assert property ( // RULE_03
		(rx_mode_in == LPI_M_ALERT && r.rxm_prev != LPI_M_ALERT) |=>
		rx_lane_out.dat == {LANES{ALERT_PAT[15:8]}} ##1
		($past(rx_mode_in) != LPI_M_ALERT || rx_lane_out.dat == {LANES{ALERT_PAT[7:0]}})
	) else $error("rx alert pattern wrong");

	rx_quiet_off_a: assert property ( // RULE_04
		rx_mode_in == LPI_M_QUIET |=> !rx_lane_en
	) else $error("rx lanes on in quiet");

	sd_drop_a: assert property ( // RULE_05
		(r.rxm_prev == LPI_M_DATA && rx_mode_in == LPI_M_QUIET) |=> !signal_ok
	) else $error("detect kept on quiet entry");

	sd_raise_a: assert property ( // RULE_06
		(rx_mode_in == LPI_M_QUIET && rx_alert_pin)[*4] |-> ##[0:SD_LIMIT] signal_ok
	) else $error("detect slow after alert");

	sd_cause_a: assert property ( // RULE_07
		(rx_mode_in == LPI_M_QUIET && $past(rx_mode_in) == LPI_M_QUIET && $rose(signal_ok)) |->
		$past(r.alert_s2)
	) else $error("detect rose without alert");

	fault_wins_a: assert property ( // RULE_08
		fault_request |=> tx_lane_out.ctl == FAULT_CTL && tx_lane_out.dat == FAULT_DAT && tx_mode == LPI_M_DATA
	) else $error("fault not sent");

	wake_hold_a: assert property ( // RULE_09
		($rose(r.st == LPI_S_WAKE) && !$past(fast_wake_select))
		|-> r.cnt == ($past(scrambler_bypass_on) ? WAKE_CYC_BYP : WAKE_CYC_SCR)
	) else $error("wake hold wrong");

	mode_legal_a: assert property ( // RULE_11
		tx_mode inside {LPI_M_DATA, LPI_M_SLEEP, LPI_M_QUIET, LPI_M_FW, LPI_M_ALERT}
	) else $error("illegal tx mode");

	alert_stop_a: assert property ( // RULE_13
		(tx_mode == LPI_M_ALERT ##1 tx_mode != LPI_M_ALERT && !fault_request) |->
		tx_lane_out.dat != {LANES{ALERT_PAT[15:8]}} || tx_lane_out.ctl != CTL_NONE
	) else $error("pattern ran on");

	alert_seq_a: assert property ( // RULE_13
		(tx_mode != LPI_M_ALERT && next_r.mode == LPI_M_ALERT && shutdown_en ##1
		next_r.mode == LPI_M_ALERT && shutdown_en) |-> alert_two_words
	) else $error("alert sequence broken");
endmodule : lpi_ctrl

// ### tb/lpi_partner.sv
`timescale 1ns/100ps
module lpi_partner import lpi_pkg::*; (
	input logic sys_clk,
	input lpi_mode_t mode_cmd,
	input logic alert_cmd,
	input logic noise_cmd,
	output lpi_mode_t rx_mode,
	output lpi_lane_t rx_data,
	output logic alert_pin,
	output logic energy_pin
);
	// ****
	// far-end sublayer
	// ****
	logic [31:0] seq = 32'h0;
	always @(posedge sys_clk) begin
		rx_mode <= mode_cmd;
		seq <= seq + 32'h01010101;
	end
	// data never freezes, so a stale word cannot pass
	assign rx_data = {4'h0, seq};
	// released line: energy only from alert or noise
	assign energy_pin = rx_mode != LPI_M_QUIET || alert_cmd || noise_cmd;
	assign alert_pin = alert_cmd;
endmodule : lpi_partner

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top import lpi_pkg::*; ;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic shutdown_en = 1'b1, fast_wake_select = 1'b0, scrambler_bypass_on = 1'b0;
	logic lpi_request = 1'b0, fault_request = 1'b0, alert_cmd = 1'b0, noise_cmd = 1'b0;
	lpi_lane_t tx_data_in = '0;
	lpi_mode_t mode_cmd = LPI_M_DATA;
	lpi_mode_t tx_mode, rx_mode_in;
	lpi_lane_t tx_lane_out, rx_lane_out, rx_data_in;
	logic tx_lane_en, rx_lane_en, signal_ok, rx_alert_pin, rx_energy_pin;
	logic [31:0] a;
	int err_count = 0;
	int comparisons = 0;
	int n0, n1;
	always #5 sys_clk = ~sys_clk;
	lpi_ctrl lpi_ctrl_i (.sys_clk(sys_clk), .rst(rst), .shutdown_en(shutdown_en),
		.fast_wake_select(fast_wake_select), .scrambler_bypass_on(scrambler_bypass_on),
		.lpi_request(lpi_request), .fault_request(fault_request), .tx_data_in(tx_data_in),
		.rx_mode_in(rx_mode_in), .rx_data_in(rx_data_in), .rx_alert_pin(rx_alert_pin),
		.rx_energy_pin(rx_energy_pin), .tx_mode(tx_mode), .tx_lane_out(tx_lane_out),
		.tx_lane_en(tx_lane_en), .rx_lane_out(rx_lane_out), .rx_lane_en(rx_lane_en),
		.signal_ok(signal_ok));
	lpi_partner lpi_partner_i (.sys_clk(sys_clk), .mode_cmd(mode_cmd), .alert_cmd(alert_cmd),
		.noise_cmd(noise_cmd), .rx_mode(rx_mode_in), .rx_data(rx_data_in),
		.alert_pin(rx_alert_pin), .energy_pin(rx_energy_pin));
	// ****
	// helpers
	// ****
	task chk(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task results;
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	// settle past the edge before sampling
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	// bounded wait, returns cycles spent
	task wait_mode(input lpi_mode_t m, output int n);
		n = 0;
		while (tx_mode !== m && n < 1000) begin
			cyc(1);
			n++;
		end
		if (n == 1000) begin
			err_count++;
			results();
		end
	endtask : wait_mode
	// one sleep, quiet, alert, wake round trip
	task lpi_cycle(input logic byp, output int n);
		@(posedge sys_clk);
		scrambler_bypass_on <= byp;
		lpi_request <= 1'b1;
		cyc(1);
		chk(36'(tx_mode), 36'(LPI_M_SLEEP));
		chk(tx_lane_out, {CTL_ALL, LPI_DAT});
		wait_mode(LPI_M_QUIET, n);
		chk(36'(tx_lane_en), 36'h0);
		@(posedge sys_clk);
		lpi_request <= 1'b0;
		cyc(1);
		chk({tx_mode, tx_lane_en, tx_lane_out.dat}, {LPI_M_ALERT, 1'b1, 32'hffffffff});
		cyc(1);
		chk(36'(tx_lane_out.dat), 36'h0);
		wait_mode(LPI_M_DATA, n);
	endtask : lpi_cycle
	// ****
	// main sequence
	// ****
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		tx_data_in <= {4'h0, 32'h12345678};
		cyc(2);
		chk(tx_lane_out, {4'h0, 32'h12345678});
		@(posedge sys_clk);
		fault_request <= 1'b1;
		lpi_request <= 1'b1;
		cyc(3);
		chk({tx_mode, tx_lane_out}, {LPI_M_DATA, FAULT_CTL, FAULT_DAT});
		@(posedge sys_clk);
		fault_request <= 1'b0;
		lpi_request <= 1'b0;
		cyc(2);
		lpi_cycle(1'b0, n0);
		lpi_cycle(1'b1, n1);
		chk(36'(n0 - n1), 36'(WAKE_CYC_SCR - WAKE_CYC_BYP));
		@(posedge sys_clk);
		fast_wake_select <= 1'b1;
		lpi_request <= 1'b1;
		cyc(1);
		chk({tx_mode, tx_lane_en}, {LPI_M_FW, 1'b1});
		@(posedge sys_clk);
		lpi_request <= 1'b0;
		wait_mode(LPI_M_DATA, n0);
		// without shutdown the wake word stays the idle word
		@(posedge sys_clk);
		fast_wake_select <= 1'b0;
		shutdown_en <= 1'b0;
		lpi_request <= 1'b1;
		wait_mode(LPI_M_QUIET, n0);
		@(posedge sys_clk);
		lpi_request <= 1'b0;
		cyc(2);
		chk({tx_mode, tx_lane_en, tx_lane_out}, {LPI_M_ALERT, 1'b1, CTL_ALL, LPI_DAT});
		wait_mode(LPI_M_DATA, n0);
		@(posedge sys_clk);
		mode_cmd <= LPI_M_QUIET;
		cyc(6);
		chk({signal_ok, rx_lane_en}, 2'b00);
		@(posedge sys_clk);
		noise_cmd <= 1'b1;
		cyc(8);
		chk(36'(signal_ok), 36'h0);
		@(posedge sys_clk);
		alert_cmd <= 1'b1;
		cyc(SD_MAX_CYC);
		chk(36'(signal_ok), 36'h1);
		@(posedge sys_clk);
		mode_cmd <= LPI_M_ALERT;
		cyc(3);
		a = rx_lane_out.dat;
		cyc(1);
		chk(36'(a), 36'({LANES{ALERT_PAT[7:0]}}));
		chk({rx_lane_en, rx_lane_out}, {1'b1, CTL_NONE, {LANES{ALERT_PAT[15:8]}}});
		results();
	end
endmodule : tb_top
